// ---- hdl/logic_string_op_decoder.sv ----
// Decoder and timer for bitwise logic and string instructions.
// Assumes one byte on byte_in per cycle with byte_valid; stalls with byte_ready low.
`timescale 1ns/1ps

module logic_string_op_decoder (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  input  wire logic [7:0]                byte_in,
  input  wire logic                      byte_valid,
  output logic                           byte_ready,
  input  wire logic                      protected_mode,
  input  wire logic                      io_perm_slow,
  input  wire logic [31:0]               counter_register,
  input  wire logic                      addr32,
  output logic_string_pkg::decode_s      decoded,
  output logic                           decoded_valid,
  output logic                           op_busy,
  output logic                           op_done,
  output logic [15:0]                    op_clocks,
  output logic                           illegal_op
);
  import logic_string_pkg::*;

  typedef enum {ST_OPCODE, ST_MODRM, ST_IMM, ST_EXEC} dec_state_e;

  dec_state_e  state_reg;
  logic [7:0]  opcode_reg;
  logic        rep_reg;
  logic        needs_imm;
  logic [2:0]  imm_left_reg;
  decode_s     dec_next;
  decode_s     dec_reg;
  logic        dec_illegal;
  logic        timer_load;
  logic [15:0] timer_cycles;
  logic        timer_busy;
  logic        timer_done;
  logic [15:0] rep_count;
  logic [2:0]  imm_bytes;

  // Immediate length follows operand size; word immediates are 4 bytes when addr32 is set
  assign imm_bytes = ~dec_next.word_size ? 3'h1 : (addr32 ? 3'h4 : 3'h2);

  // Opcode and modrm classification; runs on the byte held in the current state
  always_comb begin
    logic [1:0] mod_f;
    logic [2:0] reg_f;
    logic       is_reg;
    mod_f    = byte_in[7:6];
    reg_f    = byte_in[5:3];
    is_reg   = (mod_f == MOD_REG);
    dec_next = '0;
    dec_next.op   = OPC_NONE;
    dec_next.form = FMT_NONE;
    dec_next.word_size   = opcode_reg[0];
    dec_next.reg_is_dest = opcode_reg[1];
    dec_next.repeat_eq   = rep_reg;
    dec_next.reg_field   = reg_f;
    dec_next.rm_field    = byte_in[2:0];
    dec_illegal = 1'b0;
    needs_imm   = 1'b0;
    if (state_reg == ST_MODRM) begin
      // Two-operand forms: register modrm means register-to-register
      if ((opcode_reg & OPM_6) == OP_AND_RR || (opcode_reg & OPM_6) == OP_OR_RM
          || (opcode_reg & OPM_6) == OP_XOR_RM) begin
        dec_next.op = ((opcode_reg & OPM_6) == OP_AND_RR) ? OPC_AND :
                      ((opcode_reg & OPM_6) == OP_OR_RM)  ? OPC_OR : OPC_XOR;
        if (is_reg) begin
          dec_next.form   = FMT_RR;
          dec_next.clocks = CLK_2;
        end else if (opcode_reg[1]) begin
          dec_next.form   = FMT_MR;
          dec_next.clocks = CLK_6;
        end else begin
          dec_next.form   = FMT_RM;
          dec_next.clocks = CLK_7;
        end
      end else if ((opcode_reg & OPM_7) == OP_TEST_RM) begin
        dec_next.op     = OPC_TEST;                  // Flags only, result dropped
        dec_next.form   = is_reg ? FMT_RR : FMT_RM;
        dec_next.clocks = is_reg ? CLK_2 : CLK_5;
      end else if ((opcode_reg & OPM_7) == OP_GRP_IMM) begin
        dec_next.form   = FMT_IMM_RM;
        dec_next.clocks = is_reg ? CLK_2 : CLK_7;
        needs_imm       = 1'b1;
        case (reg_f)
          EXT_AND: dec_next.op = OPC_AND;
          EXT_OR:  dec_next.op = OPC_OR;
          EXT_XOR: dec_next.op = OPC_XOR;
          default: dec_illegal = 1'b1;               // Other group members are not ours
        endcase
      end else begin
        // Group 1111011w: test immediate or invert
        case (reg_f)
          EXT_TEST: begin
            dec_next.op     = OPC_TEST;
            dec_next.form   = FMT_IMM_RM;
            dec_next.clocks = is_reg ? CLK_2 : CLK_5;
            needs_imm       = 1'b1;
          end
          EXT_NOT: begin
            dec_next.op     = OPC_NOT;
            dec_next.form   = FMT_RR;
            dec_next.clocks = is_reg ? CLK_2 : CLK_6;
          end
          default: dec_illegal = 1'b1;
        endcase
      end
    end else begin
      // Single-byte opcodes: accumulator short forms and strings
      dec_next.word_size   = byte_in[0];
      dec_next.reg_is_dest = 1'b1;
      dec_next.reg_field   = 3'h0;
      dec_next.rm_field    = 3'h0;
      dec_next.form        = FMT_STRING;
      case (byte_in & OPM_7)
        OP_AND_AI: begin
          dec_next.op     = OPC_AND;
          dec_next.form   = FMT_IMM_ACC;
          dec_next.clocks = CLK_2;
        end
        OP_OR_AI: begin
          dec_next.op     = OPC_OR;
          dec_next.form   = FMT_IMM_ACC;
          dec_next.clocks = CLK_2;
        end
        OP_XOR_AI: begin
          dec_next.op     = OPC_XOR;
          dec_next.form   = FMT_IMM_ACC;
          dec_next.clocks = CLK_2;
        end
        OP_TEST_AI: begin
          dec_next.op     = OPC_TEST;
          dec_next.form   = FMT_IMM_ACC;
          dec_next.clocks = CLK_2;
        end
        OP_CMP_STR: begin
          dec_next.op     = OPC_CMP_STR;
          dec_next.clocks = CLK_10;
        end
        OP_LOAD_STR: begin
          dec_next.op     = OPC_LOAD_STR;
          dec_next.clocks = CLK_5;
        end
        OP_MOVE_STR: begin
          dec_next.op     = OPC_MOVE_STR;
          dec_next.clocks = CLK_7;
        end
        OP_SCAN_STR: begin
          dec_next.op     = OPC_SCAN_STR;
          dec_next.clocks = CLK_7;
        end
        OP_STORE_STR: begin
          dec_next.op     = OPC_STORE_STR;
          dec_next.clocks = CLK_4;
        end
        // Mode pins are read at decode; a mode change after that does not alter the count
        OP_PIN_STR: begin
          dec_next.op     = OPC_PIN_STR;
          dec_next.clocks = !protected_mode ? CLK_15 : (io_perm_slow ? CLK_29 : CLK_9);
        end
        OP_POUT_STR: begin
          dec_next.op     = OPC_POUT_STR;
          dec_next.clocks = !protected_mode ? CLK_14 : (io_perm_slow ? CLK_28 : CLK_8);
        end
        default: begin
          dec_next.form = FMT_NONE;
          dec_illegal   = 1'b1;
        end
      endcase
      if (dec_next.form == FMT_IMM_ACC) begin
        needs_imm = 1'b1;
      end
      // The repeat prefix is only defined here for compare string
      if (rep_reg && dec_next.op != OPC_CMP_STR) begin
        dec_illegal = 1'b1;
      end
    end
  end

  // Bytes that start a modrm form
  function automatic logic has_modrm(input logic [7:0] b);
    has_modrm = ((b & OPM_6) == OP_AND_RR) || ((b & OPM_6) == OP_OR_RM) || ((b & OPM_6) == OP_XOR_RM)
                || ((b & OPM_7) == OP_TEST_RM) || ((b & OPM_7) == OP_GRP_IMM) || ((b & OPM_7) == OP_GRP_F6);
  endfunction

  // Repetition total: base plus per-count cost; count is counter_register[15:0] for either address size
  assign rep_count    = addr32 ? counter_register[15:0] : counter_register[15:0];
  assign timer_cycles = dec_reg.repeat_eq
                        ? 16'(REP_BASE) + 16'(REP_EACH) * rep_count
                        : {8'h00, dec_reg.clocks};
  assign timer_load   = ce && (state_reg == ST_EXEC) && !timer_busy && !decoded_valid;

  // Byte acceptance: stall the stream while an instruction is being timed
  assign byte_ready = (state_reg != ST_EXEC);

  // Decode sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg    <= ST_OPCODE;
      opcode_reg   <= 8'h00;
      rep_reg      <= 1'b0;
      imm_left_reg <= 3'h0;
      dec_reg      <= '0;
      illegal_op   <= 1'b0;
    end else if (ce) begin
      illegal_op <= 1'b0;
      case (state_reg)
        ST_OPCODE: begin
          if (byte_valid) begin
            if (byte_in == OP_REP_EQ && !rep_reg) begin
              rep_reg <= 1'b1;
            end else if (has_modrm(byte_in)) begin
              if (rep_reg) begin
                illegal_op <= 1'b1;
                rep_reg    <= 1'b0;
              end else begin
                opcode_reg <= byte_in;
                state_reg  <= ST_MODRM;
              end
            end else if (dec_illegal) begin
              illegal_op <= 1'b1;
              rep_reg    <= 1'b0;
            end else begin
              dec_reg      <= dec_next;
              imm_left_reg <= imm_bytes;
              state_reg    <= needs_imm ? ST_IMM : ST_EXEC;
            end
          end
        end
        ST_MODRM: begin
          if (byte_valid) begin
            if (dec_illegal) begin
              illegal_op <= 1'b1;
              state_reg  <= ST_OPCODE;
            end else begin
              dec_reg      <= dec_next;
              imm_left_reg <= imm_bytes;
              state_reg    <= needs_imm ? ST_IMM : ST_EXEC;
            end
          end
        end
        ST_IMM: begin
          // Immediate bytes are consumed and not kept; the datapath captures them
          if (byte_valid) begin
            imm_left_reg <= imm_left_reg - 3'h1;
            if (imm_left_reg == 3'h1) begin
              state_reg <= ST_EXEC;
            end
          end
        end
        ST_EXEC: begin
          if (timer_done) begin
            state_reg <= ST_OPCODE;
            rep_reg   <= 1'b0;
          end
        end
        default: state_reg <= ST_OPCODE;
      endcase
    end
  end

  // Decoded result pulses once as the timer starts
  always_ff @(posedge clk) begin
    if (rst) begin
      decoded_valid <= 1'b0;
      decoded       <= '0;
      op_clocks     <= 16'h0000;
    end else if (ce) begin
      decoded_valid <= timer_load;
      if (timer_load) begin
        decoded   <= dec_reg;
        op_clocks <= timer_cycles;
      end
    end
  end

  op_timer u_timer (
    .clk    (clk),
    .rst    (rst),
    .ce     (ce),
    .load   (timer_load),
    .cycles (timer_cycles),
    .busy   (timer_busy),
    .done   (timer_done)
  );

  assign op_busy = timer_busy;
  assign op_done = timer_done;
endmodule

// ---- hdl/logic_string_pkg.sv ----
// Shared constants and carriers for the logic and string instruction decoder.
// Assumes one processor clock; the byte stream arrives one byte per enabled cycle.
package logic_string_pkg;

  // Opcode match patterns, compared under their masks
  localparam logic [7:0] OPM_7   = 8'hFE;  // Ignore w
  localparam logic [7:0] OPM_6   = 8'hFC;  // Ignore d and w
  localparam logic [7:0] OP_AND_RR   = 8'h20;  // 001000dw
  localparam logic [7:0] OP_AND_RM   = 8'h20;  // 0010000w
  localparam logic [7:0] OP_AND_MR   = 8'h22;  // 0010001w
  localparam logic [7:0] OP_AND_AI   = 8'h24;
  localparam logic [7:0] OP_GRP_IMM  = 8'h80;  // 1000000w
  localparam logic [7:0] OP_TEST_RM  = 8'h84;
  localparam logic [7:0] OP_GRP_F6   = 8'hF6;  // 1111011w
  localparam logic [7:0] OP_TEST_AI  = 8'hA8;
  localparam logic [7:0] OP_OR_RM    = 8'h08;
  localparam logic [7:0] OP_OR_MR    = 8'h0A;
  localparam logic [7:0] OP_OR_AI    = 8'h0C;
  localparam logic [7:0] OP_XOR_RM   = 8'h30;
  localparam logic [7:0] OP_XOR_MR   = 8'h32;
  localparam logic [7:0] OP_XOR_AI   = 8'h34;
  localparam logic [7:0] OP_CMP_STR   = 8'hA6;
  localparam logic [7:0] OP_PIN_STR   = 8'h6C;
  localparam logic [7:0] OP_POUT_STR  = 8'h6E;
  localparam logic [7:0] OP_LOAD_STR  = 8'hAC;
  localparam logic [7:0] OP_MOVE_STR  = 8'hA4;
  localparam logic [7:0] OP_SCAN_STR  = 8'hAE;
  localparam logic [7:0] OP_STORE_STR = 8'hAA;
  localparam logic [7:0] OP_REP_EQ    = 8'hF3;

  // Reg field extensions
  localparam logic [2:0] EXT_AND  = 3'h4;
  localparam logic [2:0] EXT_OR   = 3'h1;
  localparam logic [2:0] EXT_XOR  = 3'h6;
  localparam logic [2:0] EXT_TEST = 3'h0;
  localparam logic [2:0] EXT_NOT  = 3'h2;
  localparam logic [1:0] MOD_REG  = 2'h3;

  // Clock counts
  localparam logic [7:0] CLK_2   = 8'h02;
  localparam logic [7:0] CLK_4   = 8'h04;
  localparam logic [7:0] CLK_5   = 8'h05;
  localparam logic [7:0] CLK_6   = 8'h06;
  localparam logic [7:0] CLK_7   = 8'h07;
  localparam logic [7:0] CLK_8   = 8'h08;
  localparam logic [7:0] CLK_9   = 8'h09;
  localparam logic [7:0] CLK_10  = 8'h0A;
  localparam logic [7:0] CLK_14  = 8'h0E;
  localparam logic [7:0] CLK_15  = 8'h0F;
  localparam logic [7:0] CLK_28  = 8'h1C;
  localparam logic [7:0] CLK_29  = 8'h1D;
  localparam logic [7:0] REP_BASE = 8'h05;
  localparam logic [7:0] REP_EACH = 8'h09;

  typedef enum logic [3:0] {
    OPC_NONE, OPC_AND, OPC_OR, OPC_XOR, OPC_TEST, OPC_NOT,
    OPC_CMP_STR, OPC_PIN_STR, OPC_POUT_STR, OPC_LOAD_STR, OPC_MOVE_STR, OPC_SCAN_STR, OPC_STORE_STR
  } op_class_e;

  typedef enum logic [2:0] {
    FMT_NONE, FMT_RR, FMT_RM, FMT_MR, FMT_IMM_RM, FMT_IMM_ACC, FMT_STRING
  } op_form_e;

  // One decoded instruction
  typedef struct packed {
    op_class_e  op;
    op_form_e   form;
    logic       word_size;   // 1: word/dword operand
    logic       reg_is_dest;
    logic       repeat_eq;
    logic [2:0] reg_field;
    logic [2:0] rm_field;
    logic [7:0] clocks;      // Base clock count
  } decode_s;

endpackage

// ---- hdl/op_timer.sv ----
// Counts down the clock budget of one instruction.
// Assumes the loader is pulsed only while the timer is idle.
`timescale 1ns/1ps
module op_timer (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        load,
  input  wire logic [15:0] cycles,
  output logic             busy,
  output logic             done
);
  logic [15:0] count_reg;

  // Down counter; done pulses on the last busy clock
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= 16'h0000;
    end else if (ce) begin
      if (load) begin
        count_reg <= cycles;
      end else if (count_reg != 16'h0000) begin
        count_reg <= count_reg - 16'h0001;
      end
    end
  end

  assign busy = (count_reg != 16'h0000);
  assign done = (count_reg == 16'h0001) && ce;
endmodule

// ---- verification/logic_string_op_decoder_props.sv ----
// Timing and handshake properties of the logic and string decoder.
// Assumes it is bound to the decoder top and sees only its ports.
`timescale 1ns/1ps
module logic_string_op_decoder_props
  import logic_string_pkg::*;
(
  input wire logic            clk,
  input wire logic            rst,
  input wire logic            ce,
  input wire logic [7:0]      byte_in,
  input wire logic            byte_valid,
  input wire logic            byte_ready,
  input wire logic            protected_mode,
  input wire logic            io_perm_slow,
  input wire logic [31:0]     counter_register,
  input wire logic            addr32,
  input wire decode_s         decoded,
  input wire logic            decoded_valid,
  input wire logic            op_busy,
  input wire logic            op_done,
  input wire logic [15:0]     op_clocks,
  input wire logic            illegal_op
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [15:0] busy_cnt_reg;
  // Busy cycles so far; stalled cycles do not count toward the budget
  always_ff @(posedge clk) begin
    if (rst || !op_busy) busy_cnt_reg <= 16'h0000;
    else if (ce) busy_cnt_reg <= busy_cnt_reg + 16'h0001;
  end
  chk_length_exact: assert property (op_done && ce |-> busy_cnt_reg + 16'h0001 == op_clocks)
    else $error("busy length differs from op_clocks");
  chk_ready_held: assert property (op_busy && !op_done |-> !byte_ready)
    else $error("byte accepted while timing");
  chk_valid_once: assert property (decoded_valid && ce |=> !decoded_valid)
    else $error("decoded_valid longer than one cycle");
  chk_done_ends: assert property (op_done && ce |=> !op_busy)
    else $error("busy after done");
  chk_valid_busy: assert property (decoded_valid |-> op_busy)
    else $error("decoded_valid outside timing");
  chk_repeat_count: assert property (decoded_valid && decoded.repeat_eq
    |-> op_clocks == 16'(16'h0005 + 16'h0009 * counter_register[15:0]))
    else $error("repeat compare count wrong");
  chk_compare_ten: assert property (decoded_valid && decoded.op == OPC_CMP_STR && !decoded.repeat_eq
    |-> op_clocks == 16'h000A)
    else $error("compare string count wrong");
  chk_port_input: assert property (decoded_valid && decoded.op == OPC_PIN_STR
    |-> op_clocks == (!protected_mode ? 16'h000F : (io_perm_slow ? 16'h001D : 16'h0009)))
    else $error("port input count wrong");
  chk_acc_short: assert property (decoded_valid && decoded.form == FMT_IMM_ACC |-> op_clocks == 16'h0002)
    else $error("short form count wrong");
  chk_illegal_alone: assert property (illegal_op |-> !decoded_valid)
    else $error("illegal and valid together");
endmodule

bind logic_string_op_decoder logic_string_op_decoder_props u_props (
  .clk(clk), .rst(rst), .ce(ce), .byte_in(byte_in), .byte_valid(byte_valid), .byte_ready(byte_ready),
  .protected_mode(protected_mode), .io_perm_slow(io_perm_slow), .counter_register(counter_register),
  .addr32(addr32), .decoded(decoded), .decoded_valid(decoded_valid), .op_busy(op_busy),
  .op_done(op_done), .op_clocks(op_clocks), .illegal_op(illegal_op));

// ---- verification/byte_feeder.sv ----
// Instruction fetch model: offers queued bytes one at a time.
// Assumes the bench pushes whole instructions only after reset.
`timescale 1ns/1ps
module byte_feeder (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       byte_ready,
  output logic [7:0]      byte_in,
  output logic            byte_valid
);
  logic [7:0] q[$];
  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask
  initial begin
    byte_in = 8'h00;
    byte_valid = 1'b0;
  end
  // Byte held until taken; when idle the line toggles so stale data never looks valid
  always @(posedge clk) begin
    if (!rst && ce && byte_valid && byte_ready) void'(q.pop_front());
    if (q.size() != 0) begin
      byte_in <= q[0];
      byte_valid <= 1'b1;
    end else begin
      byte_in <= ~byte_in;
      byte_valid <= 1'b0;
    end
  end
endmodule

// ---- verification/logic_string_op_decoder_tb.sv ----
// Self-checking bench for the logic and string decoder.
// Assumes the fetch model in byte_feeder and a 125 MHz clock.
`timescale 1ns/1ps
module logic_string_op_decoder_tb;
  import logic_string_pkg::*;
  localparam logic [2:0] EXT3[3] = '{EXT_AND, EXT_OR, EXT_XOR};
  logic [7:0] ops[20] = '{8'h20, 8'h22, 8'h80, 8'h24, 8'h84, 8'hF6, 8'hA8, 8'h08, 8'h0A, 8'h0C,
    8'h30, 8'h32, 8'h34, 8'hA6, 8'h6C, 8'h6E, 8'hAC, 8'hA4, 8'hAE, 8'hAA};
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, prot = 1'b0, slow = 1'b0, addr32 = 1'b0;
  logic [31:0] cnt = 32'h0;
  logic [7:0]  byte_in;
  logic        byte_valid, byte_ready, dv, busy, done, illegal;
  decode_s     dec;
  logic [15:0] clks;
  int          failures = 0, checks_done = 0, nbusy = 0, nill = 0;
  int          exp_clk[$], exp_w[$], exp_dest[$];
  int          exp_op[$], exp_mrm[$], exp_rep[$];

  always #4 clk = ~clk;

  byte_feeder u_feed (.clk(clk), .rst(rst), .ce(ce), .byte_ready(byte_ready), .byte_in(byte_in),
    .byte_valid(byte_valid));
  logic_string_op_decoder dut (.clk(clk), .rst(rst), .ce(ce), .byte_in(byte_in), .byte_valid(byte_valid),
    .byte_ready(byte_ready), .protected_mode(prot), .io_perm_slow(slow), .counter_register(cnt),
    .addr32(addr32), .decoded(dec), .decoded_valid(dv), .op_busy(busy), .op_done(done),
    .op_clocks(clks), .illegal_op(illegal));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Model of the clock table; pushes the bytes and the expected outcome
  task automatic issue(input logic [7:0] op, input bit rep);
    logic [7:0] mrm;
    int c, ni, dest, idx;
    bit mem, has_mrm;
    op_class_e oc;
    mem = 1'($urandom);
    mrm = {mem ? 2'b00 : 2'b11, 3'($urandom), 3'($urandom % 4)};
    ni = op[0] ? (addr32 ? 4 : 2) : 1;
    dest = -1;
    has_mrm = 1'b1;
    oc = OPC_NONE;
    casez (op)
      8'b0000_10??, 8'b0010_00??, 8'b0011_00??: begin
        c = mem ? (op[1] ? 6 : 7) : 2;
        if (!mem) dest = op[1];
        ni = 0;
        oc = (op[5:4] == 2'b10) ? OPC_AND : (op[5] ? OPC_XOR : OPC_OR);
      end
      8'b1000_010?: begin
        c = mem ? 5 : 2;
        ni = 0;
        oc = OPC_TEST;
      end
      8'b1000_000?: begin
        idx = $urandom % 3;
        mrm[5:3] = EXT3[idx];
        c = mem ? 7 : 2;
        oc = (idx == 0) ? OPC_AND : ((idx == 1) ? OPC_OR : OPC_XOR);
      end
      8'b1111_011?: begin
        mrm[5:3] = {1'b0, 1'($urandom), 1'b0};
        c = mem ? (mrm[4] ? 6 : 5) : 2;
        if (mrm[4]) ni = 0;
        oc = mrm[4] ? OPC_NOT : OPC_TEST;
      end
      default: begin
        has_mrm = 1'b0;
        c = 2;
        case ({op[7:1], 1'b0})
          8'h24: oc = OPC_AND;
          8'h0C: oc = OPC_OR;
          8'h34: oc = OPC_XOR;
          8'hA8: oc = OPC_TEST;
          8'hA6: begin
            c = rep ? 5 + 9 * int'(cnt[15:0]) : 10;
            oc = OPC_CMP_STR;
          end
          8'h6C: begin
            c = prot ? (slow ? 29 : 9) : 15;
            oc = OPC_PIN_STR;
          end
          8'h6E: begin
            c = prot ? (slow ? 28 : 8) : 14;
            oc = OPC_POUT_STR;
          end
          8'hAC: begin
            c = 5;
            oc = OPC_LOAD_STR;
          end
          8'hA4: begin
            c = 7;
            oc = OPC_MOVE_STR;
          end
          8'hAE: begin
            c = 7;
            oc = OPC_SCAN_STR;
          end
          8'hAA: begin
            c = 4;
            oc = OPC_STORE_STR;
          end
          default: oc = OPC_NONE;
        endcase
        if (c != 2) ni = 0;
      end
    endcase
    if (rep) u_feed.push(8'hF3);
    u_feed.push(op);
    if (has_mrm) u_feed.push(mrm);
    repeat (ni) u_feed.push(8'($urandom));
    exp_clk.push_back(c);
    exp_w.push_back(int'(op[0]));
    exp_dest.push_back(dest);
    exp_op.push_back(int'(oc));
    exp_mrm.push_back(has_mrm ? int'(mrm) : -1);
    exp_rep.push_back(int'(rep));
  endtask

  task automatic wait_idle;
    int k;
    for (k = 0; k < 3000 && (exp_clk.size() != 0 || u_feed.q.size() != 0); k++) @(posedge clk);
    if (k == 3000) failures++;
    repeat (2) @(posedge clk);
  endtask

  // Random stalls exercise the clock enable, dropping it on about one cycle in eight
  always @(posedge clk) ce <= ($urandom % 8) != 0;

  // Results compared against the model at every completed operation
  always @(posedge clk) begin
    if (!rst && ce) begin
      if (illegal) nill++;
      if (busy) nbusy++;
      if (done && exp_clk.size() == 0) check("unexpected done", 32'h1, 32'h0);
      else if (done) begin
        check("op_clocks", {16'h0000, clks}, 32'(exp_clk[0]));
        check("busy cycles", 32'(nbusy), 32'(exp_clk[0]));
        check("word_size", {31'h0, dec.word_size}, 32'(exp_w[0]));
        if (exp_dest[0] >= 0) check("reg_is_dest", {31'h0, dec.reg_is_dest}, 32'(exp_dest[0]));
        check("op class", 32'(dec.op), 32'(exp_op[0]));
        check("repeat_eq", {31'h0, dec.repeat_eq}, 32'(exp_rep[0]));
        if (exp_mrm[0] >= 0) check("modrm fields", {26'h0, dec.reg_field, dec.rm_field}, 32'(exp_mrm[0] % 64));
        void'(exp_clk.pop_front());
        void'(exp_w.pop_front());
        void'(exp_dest.pop_front());
        void'(exp_op.pop_front());
        void'(exp_mrm.pop_front());
        void'(exp_rep.pop_front());
        nbusy = 0;
      end
    end
  end

  initial begin
    #(240000);
    failures++;
    test_done();
  end

  // Batches of back-to-back instructions, modes fixed within a batch
  initial begin
    void'($urandom(32'hc0982c30));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int b = 0; b < 16; b++) begin
      wait_idle();
      prot <= 1'($urandom);
      slow <= 1'($urandom);
      addr32 <= 1'($urandom);
      cnt <= 32'($urandom % 7);
      @(posedge clk);
      foreach (ops[i]) issue(ops[i] | {7'h00, 1'($urandom)}, 1'b0);
      issue(8'hA6 | {7'h00, 1'($urandom)}, 1'b1);
    end
    wait_idle();
    nill = 0;
    u_feed.push(8'hD6);
    // Prefix ahead of a non-compare string is refused as well
    u_feed.push(8'hF3);
    u_feed.push(8'hAC);
    for (int k = 0; k < 50 && nill < 2; k++) @(posedge clk);
    repeat (4) @(posedge clk);
    check("illegal pulses", 32'(nill), 32'h2);
    test_done();
  end
endmodule
